// ---- lce_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module lce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = lce_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire logic push = in_valid & in_ready;
  wire logic pop  = out_valid & out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + PW'(push);
      rd_ptr <= rd_ptr + PW'(pop);
      count  <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

module lce_host #(
  parameter logic [6:0] CHIP_ADDR = lce_pkg::CHIP_ADDR_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  lce_if.host              link
);
  localparam int QW = $clog2(lce_pkg::QUARTER_CYC);
  localparam logic [QW-1:0] Q_LAST = QW'(lce_pkg::QUARTER_CYC - 1);

  // Software-side registers
  lce_pkg::lce_op_t       op;
  logic [10:0]            addr_reg;
  logic [7:0]             wdata_reg;
  logic [3:0]             code_reg;
  logic                   nack_flag;
  logic                   go_pending;
  logic                   d_write;
  logic [31:0]            d_addr;
  // Link engine
  lce_pkg::lce_host_step_t step;
  lce_pkg::lce_host_step_t next_step;
  logic [QW-1:0]          qcnt;
  logic [1:0]             quarter;
  logic [3:0]             slot;
  logic [1:0]             sda_sync;
  logic                   ack_bad;
  logic [7:0]             rx_sh;
  logic                   fifo_ready;
  logic                   fifo_valid;
  logic [7:0]             fifo_data;

  // AHB-Lite decode; only full-word single transfers are expected
  wire logic addr_phase = hsel & hready & htrans[1];
  wire logic wr_cmd     = d_write & (d_addr == lce_pkg::REG_CMD);
  wire logic wr_addr    = d_write & (d_addr == lce_pkg::REG_ADDR);
  wire logic wr_data    = d_write & (d_addr == lce_pkg::REG_WDATA);
  wire logic wr_stat    = d_write & (d_addr == lce_pkg::REG_STATUS);
  wire logic wr_code    = d_write & (d_addr == lce_pkg::REG_CODE);
  wire logic rd_req     = addr_phase & ~hwrite;
  wire logic pop        = rd_req & (haddr == lce_pkg::REG_RDATA) & fifo_valid;
  wire logic busy       = (step != lce_pkg::H_IDLE) | go_pending;
  // Each flag widened alone, so an inverted flag cannot fill the upper bits
  wire logic [31:0] status = (32'(busy) << lce_pkg::ST_BUSY)
                           | (32'(nack_flag) << lce_pkg::ST_NACK)
                           | (32'(fifo_valid) << lce_pkg::ST_RXAVAIL)
                           | (32'(!fifo_ready) << lce_pkg::ST_FULL);
  wire logic [31:0] rd_word =
    (haddr == lce_pkg::REG_CMD)    ? 32'(op) :
    (haddr == lce_pkg::REG_ADDR)   ? 32'(addr_reg) :
    (haddr == lce_pkg::REG_WDATA)  ? 32'(wdata_reg) :
    (haddr == lce_pkg::REG_STATUS) ? status :
    (haddr == lce_pkg::REG_RDATA)  ? (fifo_valid ? 32'(fifo_data) : 32'h0) :
    (haddr == lce_pkg::REG_CODE)   ? 32'(code_reg) : 32'h0;

  // Slot timing and bus levels
  wire logic q_end     = (qcnt == Q_LAST);
  wire logic slot_end  = q_end & (quarter == 2'h3);
  wire logic is_start  = (step == lce_pkg::H_START) | (step == lce_pkg::H_RESTART);
  wire logic is_stop   = (step == lce_pkg::H_STOP);
  wire logic is_rx     = (step == lce_pkg::H_READ);
  wire logic one_slot  = is_start | is_stop;
  wire logic step_done = slot_end & (one_slot | (slot == lce_pkg::ACK_SLOT));
  wire logic sample    = q_end & (quarter == 2'h2);
  wire logic [7:0] tx_byte =
    (step == lce_pkg::H_CTRL_W) ? {code_reg, addr_reg[10:8], ~lce_pkg::DIR_READ} :
    (step == lce_pkg::H_CTRL_R) ? {code_reg, addr_reg[10:8], lce_pkg::DIR_READ} :
    (step == lce_pkg::H_WADDR)  ? addr_reg[7:0] : wdata_reg;
  wire logic [7:0] tx_sh = tx_byte << slot[2:0];
  wire logic sda_level =
    (step == lce_pkg::H_IDLE) ? 1'b1 :
    is_start ? (quarter != 2'h3) :
    is_stop  ? (quarter == 2'h3) :
    (is_rx | (slot == lce_pkg::ACK_SLOT)) ? 1'b1 : tx_sh[7];
  wire logic scl_level = (step == lce_pkg::H_IDLE) | quarter[1];
  // Reads start only with room in the FIFO: back-pressure
  wire logic can_go = go_pending & ((op == lce_pkg::LCE_OP_WRITE) | fifo_ready);

  // Command sequence per operation
  always_comb begin
    next_step = step;
    case (step)
      lce_pkg::H_IDLE:    next_step = can_go ? lce_pkg::H_START : lce_pkg::H_IDLE;
      lce_pkg::H_START:   next_step = (op == lce_pkg::LCE_OP_CUR_READ) ? lce_pkg::H_CTRL_R
                                                                      : lce_pkg::H_CTRL_W;
      lce_pkg::H_CTRL_W:  next_step = ack_bad ? lce_pkg::H_STOP : lce_pkg::H_WADDR;
      lce_pkg::H_WADDR:   next_step = ack_bad ? lce_pkg::H_STOP :
                                      (op == lce_pkg::LCE_OP_WRITE) ? lce_pkg::H_WDATA
                                                                    : lce_pkg::H_RESTART;
      lce_pkg::H_WDATA:   next_step = lce_pkg::H_STOP;
      lce_pkg::H_RESTART: next_step = lce_pkg::H_CTRL_R;
      lce_pkg::H_CTRL_R:  next_step = ack_bad ? lce_pkg::H_STOP : lce_pkg::H_READ;
      lce_pkg::H_READ:    next_step = lce_pkg::H_STOP;
      default:            next_step = lce_pkg::H_IDLE;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      d_write   <= 1'b0;
      d_addr    <= 32'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      d_write   <= addr_phase & hwrite;
      d_addr    <= haddr;
      if (rd_req) begin
        hrdata <= rd_word;
      end
    end
  end

  // Register writes; commands are ignored while busy
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      op         <= lce_pkg::LCE_OP_WRITE;
      addr_reg   <= 11'h000;
      wdata_reg  <= 8'h00;
      code_reg   <= CHIP_ADDR[lce_pkg::CHIP_ADDR_W-1 -: lce_pkg::CODE_W];
      go_pending <= 1'b0;
      nack_flag  <= 1'b0;
    end else begin
      if (wr_cmd & ~busy) begin
        op         <= lce_pkg::lce_op_t'(hwdata[1:0]);
        go_pending <= hwdata[lce_pkg::CMD_GO_BIT];
      end else if (step == lce_pkg::H_IDLE && can_go) begin
        go_pending <= 1'b0;
      end
      if (wr_addr) addr_reg <= hwdata[10:0];
      if (wr_data) wdata_reg <= hwdata[7:0];
      if (wr_code) code_reg <= hwdata[3:0];
      // A new NACK wins over a clear in the same cycle
      nack_flag <= (step_done & ~one_slot & ~is_rx & ack_bad)
                 | (nack_flag & ~(wr_stat & hwdata[lce_pkg::ST_NACK]));
    end
  end

  // Link engine: quarter counter, slot counter, sampling
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      step     <= lce_pkg::H_IDLE;
      qcnt     <= '0;
      quarter  <= 2'h0;
      slot     <= 4'h0;
      sda_sync <= 2'h3;
      ack_bad  <= 1'b0;
      rx_sh    <= 8'h00;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
      if (step == lce_pkg::H_IDLE) begin
        step <= next_step;
      end else begin
        qcnt <= q_end ? '0 : qcnt + QW'(1);
        if (q_end) quarter <= quarter + 2'h1;
        if (step_done) begin
          step <= next_step;
          slot <= 4'h0;
        end else if (slot_end) begin
          slot <= slot + 4'h1;
        end
        if (sample & is_rx & (slot != lce_pkg::ACK_SLOT)) rx_sh <= {rx_sh[6:0], sda_sync[1]};
        if (sample & (slot == lce_pkg::ACK_SLOT)) ack_bad <= sda_sync[1];
      end
    end
  end

  // Pins from flops; enable means pulling the wire low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      link.scl_host_oe  <= 1'b0;
      link.sda_host_oe  <= 1'b0;
      link.scl_host_out <= 1'b0;
      link.sda_host_out <= 1'b0;
    end else begin
      link.scl_host_oe  <= ~scl_level;
      link.sda_host_oe  <= ~sda_level;
      link.scl_host_out <= 1'b0;
      link.sda_host_out <= 1'b0;
    end
  end

  lce_fifo #(.WIDTH(8), .DEPTH(lce_pkg::FIFO_DEPTH)) u_rx_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (step_done & is_rx),
    .in_ready  (fifo_ready),
    .in_data   (rx_sh),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );
endmodule
`default_nettype wire

// ---- lce_pkg.sv ----
// Behaviour
// - Control byte opens with programmable four-bit code
// - Next three bits are block address bits
// - Last control bit: one reads, zero writes
// - Device acknowledges each accepted control byte
// - Word address follows, joined with block bits
// - Byte write: control, address, data, then stop
// - Data committed when its acknowledge is driven
// - Repeated start abandons write, keeps address
// - Random read: second control byte, eight bits out
// - Regulator off whenever enable pin is low
// - Lock options block reads/writes of protected bits
`default_nettype none
package lce_pkg;
  // Bus addressing
  localparam int         CHIP_ADDR_W       = 7;
  localparam logic [6:0] CHIP_ADDR_DEFAULT = 7'h08;
  localparam int         ADDR_W            = 11;
  localparam int         BLK_W             = 3;
  localparam int         CODE_W            = 4;
  localparam int         CTRL_CODE_POS     = 4;
  localparam int         BLK_POS           = 1;
  localparam int         DIR_POS           = 0;
  localparam logic       DIR_READ          = 1'b1;
  localparam logic [3:0] BYTE_BITS         = 4'h8;
  // Configuration space layout
  localparam int         CODE_FIELD_LO     = 1864;
  localparam int         CODE_FIELD_HI     = 1867;
  localparam int         CODE_BYTE         = CODE_FIELD_LO / 8;
  localparam int         CODE_LSB          = CODE_FIELD_LO % 8;
  localparam int         LOCK_FIELD_HI     = 1535;
  localparam int         LOCK_BYTE_LAST    = LOCK_FIELD_HI / 8;
  localparam int         MEM_BYTES_DEFAULT = 256;
  localparam logic [7:0] NO_DATA           = 8'hff;
  // Host bit timing: four quarters per bit slot
  localparam int         SYS_CLK_NS        = 25;
  localparam int         QUARTER_NS        = 650;
  localparam int         QUARTER_CYC       = (QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [3:0] ACK_SLOT          = 4'h8;
  // Host register map (byte addresses)
  localparam logic [31:0] REG_CMD          = 32'h0000_0000;
  localparam logic [31:0] REG_ADDR         = 32'h0000_0004;
  localparam logic [31:0] REG_WDATA        = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS       = 32'h0000_000c;
  localparam logic [31:0] REG_RDATA        = 32'h0000_0010;
  localparam logic [31:0] REG_CODE         = 32'h0000_0014;
  localparam int          CMD_GO_BIT       = 2;
  localparam int          ST_BUSY          = 0;
  localparam int          ST_NACK          = 1;
  localparam int          ST_RXAVAIL       = 2;
  localparam int          ST_FULL          = 3;
  localparam int          FIFO_DEPTH       = 8;

  typedef enum logic [1:0] {LCE_OP_WRITE, LCE_OP_RAND_READ, LCE_OP_CUR_READ} lce_op_t;
  typedef enum logic [3:0] {
    D_IDLE, D_CTRL, D_CTRL_ACK, D_ADDR, D_ADDR_ACK,
    D_WDATA, D_WDATA_ACK, D_RDATA, D_MACK
  } lce_dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE, H_START, H_CTRL_W, H_WADDR, H_WDATA,
    H_RESTART, H_CTRL_R, H_READ, H_STOP
  } lce_host_step_t;
endpackage
`default_nettype wire

// ---- lce_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface lce_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-up; any enabled low driver wins
  assign scl = ~(scl_host_oe & ~scl_host_out);
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));

  modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
  modport host (
    input  scl,
    input  sda,
    output scl_host_out,
    output scl_host_oe,
    output sda_host_out,
    output sda_host_oe
  );
endinterface
`default_nettype wire

// ---- lce_dev.sv ----
`timescale 1ns/100ps
`default_nettype none
module lce_dev #(
  parameter logic [6:0] CHIP_ADDR = lce_pkg::CHIP_ADDR_DEFAULT,
  parameter int         MEM_BYTES = lce_pkg::MEM_BYTES_DEFAULT
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  lce_if.dev        link,
  input  wire logic regulator_enable_pin,
  input  wire logic output_level_select_pin,
  input  wire logic lock_read_low,
  input  wire logic lock_write_low,
  input  wire logic lock_write_all,
  output var  logic regulator_on,
  output var  logic regulator_level_high
);
  localparam int AW    = lce_pkg::ADDR_W;
  localparam int IDX_W = $clog2(MEM_BYTES);
  localparam logic [7:0] CODE_RESET =
    8'(CHIP_ADDR[lce_pkg::CHIP_ADDR_W-1 -: lce_pkg::CODE_W]) << lce_pkg::CODE_LSB;

  // Memory must reach the code byte and stay inside the address space
  if (MEM_BYTES <= lce_pkg::CODE_BYTE || MEM_BYTES > (1 << AW)) begin : g_chk
    $error("MEM_BYTES out of range");
  end

  // Synchronisers and edge history
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] en_sync;
  logic [1:0] sel_sync;
  logic       scl_d;
  logic       sda_d;

  // Protocol state
  lce_pkg::lce_dev_state_t state;
  logic [3:0]              cnt;
  logic [7:0]              sh;
  logic [2:0]              blk;
  logic [AW-1:0]           ptr;
  logic                    is_read;
  logic                    mnack;
  logic [7:0]              mem [MEM_BYTES];

  // Cleaned bus levels and events
  wire logic scl_s      = scl_sync[1];
  wire logic sda_s      = sda_sync[1];
  wire logic scl_rise   = scl_s & ~scl_d;
  wire logic scl_fall   = ~scl_s & scl_d;
  wire logic start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire logic stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  // Control byte fields
  wire logic [3:0] ctrl_code = mem[lce_pkg::CODE_BYTE][lce_pkg::CODE_LSB +: lce_pkg::CODE_W];
  wire logic [3:0] rx_code   = sh[lce_pkg::CTRL_CODE_POS +: lce_pkg::CODE_W];
  wire logic [2:0] rx_blk    = sh[lce_pkg::BLK_POS +: lce_pkg::BLK_W];
  wire logic       rx_dir    = sh[lce_pkg::DIR_POS];
  wire logic ctrl_match      = (rx_code == ctrl_code);

  // Byte reception
  wire logic rx_state = (state == lce_pkg::D_CTRL) | (state == lce_pkg::D_ADDR)
                      | (state == lce_pkg::D_WDATA);
  wire logic rx_done  = rx_state & scl_fall & (cnt == lce_pkg::BYTE_BITS);

  // Address range and lock decode
  wire logic [IDX_W-1:0] idx = ptr[IDX_W-1:0];
  wire logic in_range   = (int'(ptr) < MEM_BYTES); // Int compare: a full map stays in range
  wire logic low_zone   = (ptr <= AW'(lce_pkg::LOCK_BYTE_LAST));
  wire logic rd_blocked = lock_read_low & low_zone;
  wire logic wr_blocked = lock_write_all | (lock_write_low & low_zone);
  wire logic [7:0] rd_byte = (in_range & ~rd_blocked) ? mem[idx] : lce_pkg::NO_DATA;

  // Acknowledge state that follows each received byte
  wire lce_pkg::lce_dev_state_t ack_state =
    (state == lce_pkg::D_CTRL) ? lce_pkg::D_CTRL_ACK :
    (state == lce_pkg::D_ADDR) ? lce_pkg::D_ADDR_ACK : lce_pkg::D_WDATA_ACK;

  // Write happens with the data acknowledge, if not locked
  wire logic commit = rx_done & (state == lce_pkg::D_WDATA) & in_range & ~wr_blocked;

  // Read byte is loaded after control ack or a master ack
  wire logic load_rd = scl_fall & (((state == lce_pkg::D_CTRL_ACK) & is_read)
                     | ((state == lce_pkg::D_MACK) & ~mnack));

  // Two flops on SCL and SDA before use; bus idles high
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  // Regulator control; level is meaningless while off so kept low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_sync              <= 2'h0;
      sel_sync             <= 2'h0;
      regulator_on         <= 1'b0;
      regulator_level_high <= 1'b0;
    end else begin
      en_sync              <= {en_sync[0], regulator_enable_pin};
      sel_sync             <= {sel_sync[0], output_level_select_pin};
      regulator_on         <= en_sync[1];
      regulator_level_high <= en_sync[1] & sel_sync[1];
    end
  end

  // Configuration storage; only the code byte has a non-zero reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= (i == lce_pkg::CODE_BYTE) ? CODE_RESET : 8'h00;
      end
    end else if (commit) begin
      mem[idx] <= sh;
    end
  end

  // Bit-level protocol engine. Data changes only on the SCL fall,
  // so SDA never moves while SCL is high except by the master.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state            <= lce_pkg::D_IDLE;
      cnt              <= 4'h0;
      sh               <= 8'h00;
      blk              <= 3'h0;
      ptr              <= '0;
      is_read          <= 1'b0;
      mnack            <= 1'b0;
      link.sda_dev_oe  <= 1'b0;
      link.sda_dev_out <= 1'b0;
    end else begin
      link.sda_dev_out <= 1'b0;
      if (start_seen) begin
        // Any half-done write is dropped; ptr survives
        state           <= lce_pkg::D_CTRL;
        cnt             <= 4'h0;
        link.sda_dev_oe <= 1'b0;
      end else if (stop_seen) begin
        state           <= lce_pkg::D_IDLE;
        link.sda_dev_oe <= 1'b0;
      end else if (rx_state & scl_rise) begin
        // Sample on the rising clock, MSB first
        sh  <= {sh[6:0], sda_s};
        cnt <= cnt + 4'h1;
      end else if (rx_done) begin
        cnt <= 4'h0;
        if ((state == lce_pkg::D_CTRL) & ~ctrl_match) begin
          state <= lce_pkg::D_IDLE;
        end else begin
          // Ack slot driven right after the eighth bit
          state           <= ack_state;
          link.sda_dev_oe <= 1'b1;
          if (state == lce_pkg::D_CTRL) begin
            blk     <= rx_blk;
            is_read <= (rx_dir == lce_pkg::DIR_READ);
          end else if (state == lce_pkg::D_ADDR) begin
            ptr <= {blk, sh};
          end else begin
            ptr <= ptr + AW'(1);
          end
        end
      end else if (load_rd) begin
        // First read bit goes out on the fall ending the ack
        state           <= lce_pkg::D_RDATA;
        sh              <= rd_byte;
        cnt             <= 4'h0;
        ptr             <= ptr + AW'(1);
        link.sda_dev_oe <= ~rd_byte[7];
      end else begin
        case (state)
          lce_pkg::D_CTRL_ACK: begin
            if (scl_fall) begin
              // Write direction continues with the word address
              state           <= lce_pkg::D_ADDR;
              link.sda_dev_oe <= 1'b0;
            end
          end
          lce_pkg::D_ADDR_ACK, lce_pkg::D_WDATA_ACK: begin
            if (scl_fall) begin
              state           <= lce_pkg::D_WDATA;
              link.sda_dev_oe <= 1'b0;
            end
          end
          lce_pkg::D_RDATA: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              if (cnt == lce_pkg::BYTE_BITS) begin
                state           <= lce_pkg::D_MACK;
                link.sda_dev_oe <= 1'b0;
              end else begin
                sh              <= {sh[6:0], 1'b0};
                link.sda_dev_oe <= ~sh[6];
              end
            end
          end
          lce_pkg::D_MACK: begin
            // A master NACK ends the read; wait for stop or start
            if (scl_rise) begin
              mnack <= sda_s;
            end else if (scl_fall) begin
              state <= lce_pkg::D_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- lce_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module lce_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_host_out,
  input wire logic scl_host_oe,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  // One domain, so one clock and one disable for all
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Open drain: a driver may only ever pull low
  AST_PULL_ONLY: assert property (!scl_host_out && !sda_host_out && !sda_dev_out)
    else $error("open-drain driver drives high");
  AST_DEV_EDGE: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved data while clock high");
  AST_ACK_HOLD: assert property ($rose(sda_dev_oe) |-> !scl [*8])
    else $error("device drive started too late in the slot");
  AST_DEV_STEADY: assert property ($rose(scl) |-> $stable(sda_dev_oe) [*8])
    else $error("device data unstable while clock high");
  AST_NO_FIGHT: assert property (scl && sda_dev_oe |-> !sda_host_oe)
    else $error("host and device drive data together");
  AST_START_HOST: assert property (scl && $fell(sda) |-> !sda_dev_oe)
    else $error("start made while device drives data");
  AST_START_CLK: assert property (scl && $fell(sda) |-> ##[1:120] !scl)
    else $error("no control byte clock after start");
  AST_HIGH_WIDTH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

// ---- lce_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module lce_bench;
  logic        sys_clk, resetn, hsel, hwrite, en, sel, rlock, wlock, rdy, hresp, reg_on, reg_hi;
  logic        wall;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          miscompares, n_tests;
  lce_if lnk ();
  lce_dev #(.MEM_BYTES(512)) lce_dev_inst (.sys_clk(sys_clk), .resetn(resetn), .link(lnk.dev),
    .regulator_enable_pin(en), .output_level_select_pin(sel), .lock_read_low(rlock),
    .lock_write_low(wlock), .lock_write_all(wall), .regulator_on(reg_on),
    .regulator_level_high(reg_hi));
  lce_host lce_host_inst (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp), .link(lnk.host));
  lce_checker lce_checker_inst (.sys_clk(sys_clk), .resetn(resetn), .scl(lnk.scl), .sda(lnk.sda),
    .scl_host_out(lnk.scl_host_out), .scl_host_oe(lnk.scl_host_oe), .sda_dev_out(lnk.sda_dev_out),
    .sda_host_out(lnk.sda_host_out), .sda_host_oe(lnk.sda_host_oe), .sda_dev_oe(lnk.sda_dev_oe));

  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single-word transfer; waits on ready, never on a fixed count
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (rdy !== 1'b1);
    r = hrdata;
  endtask

  // Launch a link command and poll busy; a hang is left to the watchdog
  task automatic cmd(input logic [1:0] op, input logic [10:0] a, input logic [7:0] d);
    ahb(1'b1, lce_pkg::REG_ADDR, {21'h0, a});
    ahb(1'b1, lce_pkg::REG_WDATA, {24'h0, d});
    ahb(1'b1, lce_pkg::REG_CMD, {29'h0, 1'b1, op});
    repeat (4) @(posedge sys_clk);
    r = 32'h1;
    while (r[lce_pkg::ST_BUSY] !== 1'b0) ahb(1'b0, lce_pkg::REG_STATUS, 32'h0);
  endtask

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    cmd(lce_pkg::LCE_OP_RAND_READ, a, 8'h00);
    ahb(1'b0, lce_pkg::REG_RDATA, 32'h0);
    chk(r, {24'h0, e});
  endtask

  // Main sequence
  initial begin
    {hsel, hwrite, en, sel, rlock, wlock, wall, resetn} = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    miscompares = 0;
    n_tests = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    ahb(1'b0, lce_pkg::REG_CODE, 32'h0);
    chk(r, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b0, 32'h0000_0020, 32'h0);
    chk(r, 32'h0);
    cmd(lce_pkg::LCE_OP_WRITE, 11'h1c6, 8'h3c);
    cmd(lce_pkg::LCE_OP_WRITE, 11'h1c5, 8'ha5);
    rd(11'h1c5, 8'ha5);
    cmd(lce_pkg::LCE_OP_CUR_READ, 11'h000, 8'h00);
    // Idle, no NACK, one byte waiting, FIFO not full
    ahb(1'b0, lce_pkg::REG_STATUS, 32'h0);
    chk(r, 32'h4);
    ahb(1'b0, lce_pkg::REG_RDATA, 32'h0);
    chk(r, 32'h3c);
    // Foreign control code must go unanswered
    ahb(1'b1, lce_pkg::REG_CODE, 32'h2);
    cmd(lce_pkg::LCE_OP_WRITE, 11'h1c5, 8'h00);
    ahb(1'b0, lce_pkg::REG_STATUS, 32'h0);
    chk(r & 32'h2, 32'h2);
    ahb(1'b1, lce_pkg::REG_STATUS, 32'h2);
    ahb(1'b1, lce_pkg::REG_CODE, 32'h1);
    rd(11'h1c5, 8'ha5);
    // Locked low zone: write dropped, then read blanked
    wlock <= 1'b1;
    cmd(lce_pkg::LCE_OP_WRITE, 11'h010, 8'h77);
    rd(11'h010, 8'h00);
    rlock <= 1'b1;
    rd(11'h010, 8'hff);
    // Write-all lock: upper zone write acked but dropped
    wall <= 1'b1;
    cmd(lce_pkg::LCE_OP_WRITE, 11'h1c5, 8'h11);
    rd(11'h1c5, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      {en, sel} <= i[1:0];
      repeat (6) @(posedge sys_clk);
      chk({30'h0, reg_on, reg_hi}, {30'h0, i[1], i[1] & i[0]});
    end
    stop_test();
  end

  // Watchdog well beyond the expected run of about 40k cycles
  initial begin
    #2_000_000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
